// ---- include/ddcnd_pkg.sv ----
// Purpose: Shared constants and types for the down-converter datapath.
// Assumes: One real ADC sample per clock; all presets fed from plain ports.
// Notes: Stage tables are indexed by chain position, see ddcnd_top.
package ddcnd_pkg;
  // Oscillator sizing
  localparam int DDCND_PRESETS = 8;
  localparam int DDCND_SEL_W = 3;
  localparam int DDCND_FREQ_W = 32;
  localparam int DDCND_PHASE_W = 16;
  localparam int DDCND_RDIV_W = 14;
  // Rational mode: word = round(2^25 * N / divider)
  localparam int DDCND_RAT_SHIFT = 25;
  localparam int DDCND_PROD_W = DDCND_FREQ_W + DDCND_RDIV_W;
  localparam int DDCND_ERR_W = 28;
  // Sine table: 2 quadrant bits plus 4 index bits of phase
  localparam int DDCND_LUT_IDX_W = 4;
  localparam int DDCND_LUT_PH_W = DDCND_LUT_IDX_W + 2;
  localparam logic [4:0] DDCND_LUT_FULL = 5'h10;
  localparam logic signed [15:0] DDCND_SINE_LUT [17] = '{
    16'h0000, 16'h0C8C, 16'h18F9, 16'h2528, 16'h30FB, 16'h3C56, 16'h471C, 16'h5133,
    16'h5A82, 16'h62F1, 16'h6A6D, 16'h70E2, 16'h7641, 16'h7A7C, 16'h7D89, 16'h7F61,
    16'h7FFF};
  // Datapath widths
  localparam int DDCND_ADC_W = 12;
  localparam int DDCND_DATA_W = 16;
  localparam int DDCND_OUT_W = 15;
  localparam int DDCND_OR_W = 2;
  localparam int DDCND_DLY_W = 6;
  // Decimation settings
  typedef enum logic [2:0] {
    DDCND_DEC4 = 3'h0, DDCND_DEC8 = 3'h1, DDCND_DEC10 = 3'h2,
    DDCND_DEC16 = 3'h3, DDCND_DEC20 = 3'h4, DDCND_DEC32 = 3'h5
  } ddcnd_dec_type;
  localparam int DDCND_MODES = 6;
  localparam logic [5:0] DDCND_DEC_FACTOR [DDCND_MODES] = '{
    6'h04, 6'h08, 6'h0A, 6'h10, 6'h14, 6'h20};
  // Chain positions: 7, 7, 11, 19, 15, 55, then 139 fed from position 2
  localparam int DDCND_STAGES = 7;
  localparam int DDCND_BRANCH_SRC = 2;
  localparam int DDCND_STAGE_TAPS [DDCND_STAGES] = '{7, 7, 11, 19, 15, 55, 139};
  localparam int DDCND_STAGE_DEC [DDCND_STAGES] = '{2, 2, 2, 2, 2, 2, 5};
  localparam logic [DDCND_STAGES-1:0] DDCND_USE_MASK [DDCND_MODES] = '{
    7'h28, 7'h34, 7'h44, 7'h35, 7'h45, 7'h37};
endpackage

// ---- rtl/ddcnd_fir_stage.sv ----
// Purpose: One decimating complex FIR stage of the down-converter chain.
// Assumes: Input valid at most once per clock; odd tap count.
// Notes: Triangular taps normalised to unity gain or below.
`timescale 1ns/100ps
`default_nettype none
module ddcnd_fir_stage
  import ddcnd_pkg::*;
#(
  parameter int TAPS = 7,
  parameter int DEC = 2,
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic inValid,
  input wire logic signed [W-1:0] inI,
  input wire logic signed [W-1:0] inQ,
  output logic outValid,
  output logic signed [W-1:0] outI,
  output logic signed [W-1:0] outQ
);
  localparam int CENTER = (TAPS - 1) / 2;
  localparam int NORM = $clog2((CENTER + 1) * (CENTER + 1));
  localparam int ACC_W = W + NORM + 1;
  localparam int PH_W = $clog2(DEC + 1);

  logic signed [W-1:0] tapI [TAPS]; // Newest sample at index 0
  logic signed [W-1:0] tapQ [TAPS];
  logic [PH_W-1:0] phase; // Input count within one decimation group
  logic fire; // Group complete, produce an output next edge
  logic signed [ACC_W-1:0] sumI;
  logic signed [ACC_W-1:0] sumQ;

  // Triangular weight; symmetric so each output is linear phase
  function automatic logic signed [NORM+1:0] coef(input int k);
    int d;
    d = (k > CENTER) ? (k - CENTER) : (CENTER - k);
    return (NORM + 2)'(CENTER + 1 - d);
  endfunction

  // Products summed over the tap line
  always_comb begin
    sumI = '0;
    sumQ = '0;
    for (int k = 0; k < TAPS; k++) begin
      // Widen both factors first so the product cannot wrap at the data width
      sumI = sumI + ACC_W'(tapI[k]) * ACC_W'(coef(k));
      sumQ = sumQ + ACC_W'(tapQ[k]) * ACC_W'(coef(k));
    end
  end

  // Tap line shifts on every accepted input
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < TAPS; k++) begin
        tapI[k] <= '0;
        tapQ[k] <= '0;
      end
    end else if (ce && inValid) begin
      tapI[0] <= inI;
      tapQ[0] <= inQ;
      for (int k = 1; k < TAPS; k++) begin
        tapI[k] <= tapI[k-1];
        tapQ[k] <= tapQ[k-1];
      end
    end
  end

  // Keep one output per DEC inputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= '0;
      fire <= 1'b0;
    end else if (ce) begin
      fire <= inValid && (phase == PH_W'(DEC - 1));
      if (inValid) begin
        phase <= (phase == PH_W'(DEC - 1)) ? '0 : phase + 1'b1;
      end
    end
  end

  // Registered output, scaled back to the data width
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outValid <= 1'b0;
      outI <= '0;
      outQ <= '0;
    end else if (ce) begin
      outValid <= fire;
      if (fire) begin
        outI <= sumI[NORM+W-1:NORM];
        outQ <= sumQ[NORM+W-1:NORM];
      end
    end
  end
endmodule
`default_nettype wire

// ---- rtl/ddcnd_top.sv ----
// Purpose: NCO mixer, half-sample delay and decimation chain of the down-converter.
// Assumes: ADC samples arrive every clock on clk; select pins are asynchronous.
// Notes: Over-range bits are made elsewhere and only captured with each output word.
`timescale 1ns/100ps
`default_nettype none
module ddcnd_top
  import ddcnd_pkg::*;
#(
  parameter int DLY_DEPTH = 33
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic signed [DDCND_ADC_W-1:0] adcSample,
  input wire logic [DDCND_OR_W-1:0] overRangeIn,
  input wire logic [DDCND_PRESETS*DDCND_FREQ_W-1:0] osc_frequency_word,
  input wire logic [DDCND_PRESETS*DDCND_PHASE_W-1:0] osc_phase_offset_word,
  input wire logic [DDCND_RDIV_W-1:0] rational_step_divider,
  input wire logic rationalMode,
  input wire logic [DDCND_SEL_W-1:0] preset_select_pins,
  input wire logic [DDCND_SEL_W-1:0] preset_select_field,
  input wire logic selectFromField,
  input wire logic [2:0] decimationSetting,
  input wire logic [DDCND_DLY_W-1:0] downconv_sample_delay,
  output logic outValid,
  output logic [DDCND_OUT_W-1:0] outI,
  output logic [DDCND_OUT_W-1:0] outQ,
  output logic [DDCND_OR_W-1:0] outOverRange
);
  localparam int MIX_W = DDCND_ADC_W + DDCND_DATA_W;
  localparam int MIX_LSB = MIX_W - DDCND_DATA_W - 1;

  // Select pins come from outside; two flops before use
  logic [DDCND_SEL_W-1:0] pinSyncA;
  logic [DDCND_SEL_W-1:0] pinSync;
  // Oscillator state
  logic [DDCND_FREQ_W-1:0] acc [DDCND_PRESETS];
  logic signed [DDCND_ERR_W-1:0] err [DDCND_PRESETS];
  logic rationalOn;
  // Mixer and delay line
  logic signed [DDCND_DATA_W-1:0] cosVal;
  logic signed [DDCND_DATA_W-1:0] sinVal;
  logic signed [DDCND_ADC_W-1:0] sampleD;
  logic signed [DDCND_DATA_W-1:0] mixI;
  logic signed [DDCND_DATA_W-1:0] mixQ;
  logic signed [DDCND_DATA_W-1:0] lineI [DLY_DEPTH];
  logic signed [DDCND_DATA_W-1:0] lineQ [DLY_DEPTH];
  logic signed [DDCND_DATA_W-1:0] dlyI;
  logic signed [DDCND_DATA_W-1:0] dlyQ;
  // Stage chain
  logic stIn_v [DDCND_STAGES];
  logic signed [DDCND_DATA_W-1:0] stInI [DDCND_STAGES];
  logic signed [DDCND_DATA_W-1:0] stInQ [DDCND_STAGES];
  logic chain_v [DDCND_STAGES];
  logic signed [DDCND_DATA_W-1:0] chainI [DDCND_STAGES];
  logic signed [DDCND_DATA_W-1:0] chainQ [DDCND_STAGES];

  // Sine of a coarse phase via quarter-wave table
  function automatic logic signed [DDCND_DATA_W-1:0] sine(input logic [DDCND_LUT_PH_W-1:0] p);
    logic [4:0] idx;
    logic signed [DDCND_DATA_W-1:0] mag;
    idx = p[DDCND_LUT_IDX_W] ? (DDCND_LUT_FULL - {1'b0, p[DDCND_LUT_IDX_W-1:0]})
                             : {1'b0, p[DDCND_LUT_IDX_W-1:0]};
    mag = DDCND_SINE_LUT[idx];
    return p[DDCND_LUT_IDX_W+1] ? -mag : mag;
  endfunction

  // Synchroniser for the asynchronous select pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinSyncA <= '0;
      pinSync <= '0;
    end else if (ce) begin
      pinSyncA <= preset_select_pins;
      pinSync <= pinSyncA;
    end
  end

  // Zero divider would make rational tracking meaningless; fall back to basic
  assign rationalOn = rationalMode && (rational_step_divider != '0);

  // One accumulator per preset, all running whatever preset is active
  for (genvar p = 0; p < DDCND_PRESETS; p++) begin : g_osc
    logic [DDCND_FREQ_W-1:0] word;
    logic [DDCND_PROD_W-1:0] prod;
    logic [DDCND_PROD_W-1:0] stepCount;
    logic signed [DDCND_ERR_W-1:0] resid;
    logic signed [DDCND_ERR_W-1:0] errSum;
    logic corrDown;
    logic corrUp;
    logic signed [DDCND_ERR_W-1:0] divS;
    assign word = osc_frequency_word[p*DDCND_FREQ_W +: DDCND_FREQ_W];
    // Recover the step count from the rounded word, then track the rounding residue
    assign prod = DDCND_PROD_W'(word) * DDCND_PROD_W'(rational_step_divider);
    assign stepCount = (prod + (DDCND_PROD_W'(1) << (DDCND_RAT_SHIFT - 1))) >> DDCND_RAT_SHIFT;
    assign resid = DDCND_ERR_W'($signed(prod - (stepCount << DDCND_RAT_SHIFT)));
    assign divS = DDCND_ERR_W'({1'b0, rational_step_divider});
    assign errSum = err[p] + resid;
    // Residue of one full LSB means the accumulator ran one LSB ahead or behind
    assign corrDown = rationalOn && (errSum >= divS);
    assign corrUp = rationalOn && (errSum <= -divS);
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        acc[p] <= '0;
        err[p] <= '0;
      end else if (ce) begin
        if (corrDown) begin
          acc[p] <= acc[p] + word - 1'b1;
          err[p] <= errSum - divS;
        end else if (corrUp) begin
          acc[p] <= acc[p] + word + 1'b1;
          err[p] <= errSum + divS;
        end else begin
          acc[p] <= acc[p] + word;
          err[p] <= rationalOn ? errSum : '0;
        end
      end
    end
  end

  // Active preset: field or synchronised pins
  logic [DDCND_SEL_W-1:0] activeSel;
  logic [DDCND_PHASE_W-1:0] activeOffset;
  logic [DDCND_FREQ_W-1:0] activePhase;
  assign activeSel = selectFromField ? preset_select_field : pinSync;
  assign activeOffset = osc_phase_offset_word[activeSel*DDCND_PHASE_W +: DDCND_PHASE_W];
  // Offset sits in the top bits, so its full scale is one turn
  assign activePhase = acc[activeSel] + {activeOffset, {(DDCND_FREQ_W-DDCND_PHASE_W){1'b0}}};

  // Coarse phase into cosine and sine; sample delayed to line up
  logic [DDCND_LUT_PH_W-1:0] coarse;
  logic [DDCND_LUT_PH_W-1:0] quarterTurn;
  assign coarse = activePhase[DDCND_FREQ_W-1 -: DDCND_LUT_PH_W];
  assign quarterTurn = DDCND_LUT_PH_W'(DDCND_LUT_FULL);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cosVal <= '0;
      sinVal <= '0;
      sampleD <= '0;
    end else if (ce) begin
      cosVal <= sine(coarse + quarterTurn);
      sinVal <= sine(coarse);
      sampleD <= adcSample;
    end
  end

  // Mixer: x * exp(-j phase) brings the carrier to zero frequency
  logic signed [MIX_W-1:0] prodC;
  logic signed [MIX_W-1:0] prodS;
  logic signed [DDCND_DATA_W-1:0] negSin;
  assign prodC = sampleD * cosVal;
  assign prodS = sampleD * sinVal;
  // Product magnitude never reaches -2^15 here, so the negation is safe
  assign negSin = -prodS[MIX_LSB+DDCND_DATA_W-1:MIX_LSB];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mixI <= '0;
      mixQ <= '0;
    end else if (ce) begin
      mixI <= prodC[MIX_LSB+DDCND_DATA_W-1:MIX_LSB];
      mixQ <= negSin;
    end
  end

  // Delay line of mixed samples, newest at index 0
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < DLY_DEPTH; k++) begin
        lineI[k] <= '0;
        lineQ[k] <= '0;
      end
    end else if (ce) begin
      lineI[0] <= mixI;
      lineQ[0] <= mixQ;
      for (int k = 1; k < DLY_DEPTH; k++) begin
        lineI[k] <= lineI[k-1];
        lineQ[k] <= lineQ[k-1];
      end
    end
  end

  // Delay in half samples, clamped to 2*D-1; odd values average two taps
  logic [2:0] decSel;
  logic [DDCND_DLY_W:0] maxHalf;
  logic [DDCND_DLY_W:0] halfSteps;
  logic [DDCND_DLY_W-1:0] whole;
  logic signed [DDCND_DATA_W:0] avgI;
  logic signed [DDCND_DATA_W:0] avgQ;
  // Illegal setting codes fall back to the smallest decimation
  assign decSel = (decimationSetting > 3'(DDCND_MODES - 1)) ? 3'(DDCND_DEC4) : decimationSetting;
  assign maxHalf = {DDCND_DEC_FACTOR[decSel], 1'b0} - 1'b1;
  assign halfSteps = ({1'b0, downconv_sample_delay} > maxHalf) ? maxHalf
                                                              : {1'b0, downconv_sample_delay};
  assign whole = halfSteps[DDCND_DLY_W:1];
  // Half step is a two-tap average, a cheap interpolator with mild droop
  assign avgI = (lineI[whole] + lineI[whole + 1'b1]) >>> 1;
  assign avgQ = (lineQ[whole] + lineQ[whole + 1'b1]) >>> 1;
  assign dlyI = halfSteps[0] ? avgI[DDCND_DATA_W-1:0] : lineI[whole];
  assign dlyQ = halfSteps[0] ? avgQ[DDCND_DATA_W-1:0] : lineQ[whole];

  // Stage chain; unused positions pass their input straight through
  logic [DDCND_STAGES-1:0] useMask;
  assign useMask = DDCND_USE_MASK[decSel];
  for (genvar s = 0; s < DDCND_STAGES; s++) begin : g_stage
    logic sv;
    logic signed [DDCND_DATA_W-1:0] si;
    logic signed [DDCND_DATA_W-1:0] sq;
    if (s == 0) begin : g_head
      assign stIn_v[s] = 1'b1;
      assign stInI[s] = dlyI;
      assign stInQ[s] = dlyQ;
    end else if (s == DDCND_STAGES - 1) begin : g_branch
      assign stIn_v[s] = chain_v[DDCND_BRANCH_SRC];
      assign stInI[s] = chainI[DDCND_BRANCH_SRC];
      assign stInQ[s] = chainQ[DDCND_BRANCH_SRC];
    end else begin : g_link
      assign stIn_v[s] = chain_v[s-1];
      assign stInI[s] = chainI[s-1];
      assign stInQ[s] = chainQ[s-1];
    end
    // Complex in, complex out; decimation set per stage
    ddcnd_fir_stage #(
      .TAPS(DDCND_STAGE_TAPS[s]),
      .DEC(DDCND_STAGE_DEC[s]),
      .W(DDCND_DATA_W)
    ) u_stage (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .inValid(stIn_v[s]),
      .inI(stInI[s]),
      .inQ(stInQ[s]),
      .outValid(sv),
      .outI(si),
      .outQ(sq)
    );
    assign chain_v[s] = useMask[s] ? sv : stIn_v[s];
    assign chainI[s] = useMask[s] ? si : stInI[s];
    assign chainQ[s] = useMask[s] ? sq : stInQ[s];
  end

  // Final sample from the by-five branch or the main chain end
  logic finalV;
  logic signed [DDCND_DATA_W-1:0] finalI;
  logic signed [DDCND_DATA_W-1:0] finalQ;
  assign finalV = useMask[DDCND_STAGES-1] ? chain_v[DDCND_STAGES-1] : chain_v[DDCND_STAGES-2];
  assign finalI = useMask[DDCND_STAGES-1] ? chainI[DDCND_STAGES-1] : chainI[DDCND_STAGES-2];
  assign finalQ = useMask[DDCND_STAGES-1] ? chainQ[DDCND_STAGES-1] : chainQ[DDCND_STAGES-2];

  // A setting switch can hand over between two stage outputs on adjacent clocks;
  // dropping the second keeps the valid strobe a single-cycle pulse
  logic takeOut;
  assign takeOut = finalV && !outValid;

  // Output word: top 15 bits of each part plus over-range pair
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outValid <= 1'b0;
      outI <= '0;
      outQ <= '0;
      outOverRange <= '0;
    end else if (ce) begin
      outValid <= takeOut;
      if (takeOut) begin
        outI <= finalI[DDCND_DATA_W-1 -: DDCND_OUT_W];
        outQ <= finalQ[DDCND_DATA_W-1 -: DDCND_OUT_W];
        outOverRange <= overRangeIn;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/ddcnd_assertions.sv ----
// Purpose: Port-level assertions for the down-converter datapath.
// Assumes: One clock domain; rst asynchronous, active high.
// Notes: Spacing checks wait for eight outputs after any setting change.
`timescale 1ns/100ps
`default_nettype none
module ddcnd_assertions
  import ddcnd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic signed [DDCND_ADC_W-1:0] adcSample,
  input wire logic [2:0] decimationSetting,
  input wire logic [DDCND_DLY_W-1:0] downconv_sample_delay,
  input wire logic outValid,
  input wire logic [DDCND_OUT_W-1:0] outI,
  input wire logic [DDCND_OUT_W-1:0] outQ,
  input wire logic [DDCND_OR_W-1:0] outOverRange
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [5:0] decFactor; // Expected spacing; spare codes act as four
  logic [8:0] cfgSeen; // Setting seen at the last enabled edge
  logic [3:0] outsSeen; // Outputs since the last setting change, saturating
  logic [11:0] gap; // Enabled clocks since the last output
  logic [11:0] quietRun; // Enabled clocks of zero input, saturating
  logic cfgChanged;
  assign decFactor = (decimationSetting > 3'h5) ? 6'h04 : DDCND_DEC_FACTOR[decimationSetting];
  assign cfgChanged = {decimationSetting, downconv_sample_delay} != cfgSeen;
  // Bookkeeping; a setting change restarts the output count and gap because stage phases are then arbitrary
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfgSeen <= '0;
      outsSeen <= '0;
      gap <= '0;
      quietRun <= '0;
    end else if (ce) begin
      cfgSeen <= {decimationSetting, downconv_sample_delay};
      quietRun <= (adcSample != '0) ? '0 : quietRun + {11'h000, quietRun != 12'hFFF};
      if (cfgChanged) begin
        outsSeen <= '0;
        gap <= '0;
      end else if (outValid) begin
        outsSeen <= outsSeen + {3'h0, outsSeen != 4'hF};
        gap <= 12'h001;
      end else begin
        gap <= gap + {11'h000, gap != 12'hFFF};
      end
    end
  end
  property p_rstQuiet;
    $fell(rst) |-> !outValid && outI == '0 && outQ == '0 && outOverRange == '0;
  endproperty
  a_rstQuiet: assert property (p_rstQuiet) else $error("outputs not clear after reset");
  property p_pulse;
    outValid && ce |=> !outValid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("output valid longer than one cycle");
  property p_hold;
    $changed(outI) || $changed(outQ) || $changed(outOverRange) |-> outValid;
  endproperty
  a_hold: assert property (p_hold) else $error("output word moved without valid");
  property p_freeze;
    !ce |=> $stable(outValid) && $stable(outI) && $stable(outQ);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while disabled");
  property p_rate;
    outValid && ce && !cfgChanged && outsSeen >= 4'h8 |-> gap == {6'h00, decFactor};
  endproperty
  a_rate: assert property (p_rate) else $error("output spacing wrong");
  property p_gapBound;
    !cfgChanged && outsSeen >= 4'h8 && !outValid |-> gap < {6'h00, decFactor};
  endproperty
  a_gapBound: assert property (p_gapBound) else $error("output overdue");
  property p_quiet;
    quietRun >= 12'h7D0 && outValid |-> outI == '0 && outQ == '0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("nonzero output for zero input");
  property p_alive;
    gap < 12'h9C4;
  endproperty
  a_alive: assert property (p_alive) else $error("no output for too long");
endmodule
bind ddcnd_top ddcnd_assertions u_ddcnd_chk (.clk, .rst, .ce, .adcSample, .decimationSetting,
  .downconv_sample_delay, .outValid, .outI, .outQ, .outOverRange);
`default_nettype wire

// ---- test/ddcnd_adc_model.sv ----
// Purpose: ADC core stand-in feeding the down-converter.
// Assumes: Bench picks the level; one sample per clock.
// Notes: Over-range bits count so that their capture is visible.
`timescale 1ns/100ps
`default_nettype none
module ddcnd_adc_model
  import ddcnd_pkg::*;
(
  input wire logic clk,
  input wire logic signed [DDCND_ADC_W-1:0] level,
  output logic signed [DDCND_ADC_W-1:0] adcSample,
  output logic [DDCND_OR_W-1:0] overRangeIn
);
  // One process owns both outputs; new sample each falling edge, clear of the sampling edge
  initial begin
    adcSample = '0;
    overRangeIn = '0;
    forever begin
      @(negedge clk);
      adcSample <= level;
      overRangeIn <= overRangeIn + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose: Self-checking bench for the down-converter datapath.
// Assumes: Inputs change on the falling edge; checker bound to the top.
// Notes: Sign and zero checks stand in for exact filter arithmetic.
`timescale 1ns/100ps
`default_nettype none
`define CHECK_EQ(what, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("Error %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module tb_top
  import ddcnd_pkg::*;
;
  logic clk, rst, ce, rationalMode, selectFromField, outValid;
  logic signed [DDCND_ADC_W-1:0] level, adcSample;
  logic [DDCND_OR_W-1:0] overRangeIn, outOverRange;
  logic [DDCND_PRESETS*DDCND_FREQ_W-1:0] osc_frequency_word;
  logic [DDCND_PRESETS*DDCND_PHASE_W-1:0] osc_phase_offset_word;
  logic [DDCND_RDIV_W-1:0] rational_step_divider;
  logic [DDCND_SEL_W-1:0] preset_select_pins, preset_select_field;
  logic [2:0] decimationSetting;
  logic [DDCND_DLY_W-1:0] downconv_sample_delay;
  logic [DDCND_OUT_W-1:0] outI, outQ;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0; // Hang guard
  ddcnd_top #(.DLY_DEPTH(33)) dut (.clk, .rst, .ce, .adcSample, .overRangeIn,
    .osc_frequency_word, .osc_phase_offset_word, .rational_step_divider, .rationalMode,
    .preset_select_pins, .preset_select_field, .selectFromField, .decimationSetting,
    .downconv_sample_delay, .outValid, .outI, .outQ, .outOverRange);
  ddcnd_adc_model adc (.clk, .level, .adcSample, .overRangeIn);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Hang guard: generous against roughly 5k cycles of tests
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      $display("Error timeout expected done seen hung");
      complete_run();
    end
  end
  // Magnitude well above rounding noise
  function automatic logic big(input logic [DDCND_OUT_W-1:0] v);
    return ($signed(v) > 15'sh0200) || ($signed(v) < -15'sh0200);
  endfunction
  task automatic wait_outs(input int n);
    int seen;
    int cyc;
    seen = 0;
    cyc = 0;
    while (seen < n && cyc < 20000) begin
      @(negedge clk);
      cyc++;
      if (outValid === 1'b1) begin
        seen++;
        // Model updates after this read, so this is the pair taken at the last edge
        `CHECK_EQ("outOverRange", overRangeIn, outOverRange)
      end
    end
    if (seen < n) begin
      errors++;
      $display("Error outValid count expected %0d seen %0d", n, seen);
    end
  endtask
  // Spacing of outputs for every code, spare codes included
  task automatic test_rate();
    int g;
    for (int code = 0; code < 8; code++) begin
      decimationSetting = code[2:0];
      wait_outs(12);
      g = 0;
      wait_outs(1);
      do begin
        @(negedge clk);
        g++;
      end while (outValid !== 1'b1 && g < 100);
      `CHECK_EQ("spacing", (code > 5) ? 4 : int'(DDCND_DEC_FACTOR[code]), g)
    end
    $display("test_rate done");
  endtask
  // DC input through presets 0,2,4,6 (0, 90, 180, 270 degrees), pins then field
  task automatic test_phase();
    logic [2:0] p;
    decimationSetting = 3'h0;
    downconv_sample_delay = 6'h07; // Longest delay at decimation four
    for (int k = 0; k < 4; k++) begin
      p = 3'(2 * k);
      selectFromField = (k >= 2);
      preset_select_pins = selectFromField ? 3'h1 : p; // Decoy preset when unused
      preset_select_field = selectFromField ? p : 3'h3;
      wait_outs(60);
      if (k[0]) begin
        `CHECK_EQ("outI", 15'h0000, outI)
        `CHECK_EQ("outQ sign", k == 1, outQ[14])
      end else begin
        `CHECK_EQ("outQ", 15'h0000, outQ)
        `CHECK_EQ("outI sign", k == 2, outI[14])
      end
      `CHECK_EQ("magnitude", 1'b1, big(outI) || big(outQ))
    end
    $display("test_phase done");
  endtask
  // Half-rate oscillator on DC must be filtered away, basic then rational
  task automatic test_nyquist();
    preset_select_field = 3'h0;
    rational_step_divider = 14'h0780; // Integer divider, below the advised limit
    osc_frequency_word[31:0] = 32'h80000000; // Exact word in both modes
    for (int m = 0; m < 2; m++) begin
      rationalMode = m[0];
      wait_outs(60);
      `CHECK_EQ("outI small", 1'b0, big(outI))
      `CHECK_EQ("outQ small", 1'b0, big(outQ))
    end
    osc_frequency_word[31:0] = 32'h00000000; // No link here, so no re-init owed
    rationalMode = 1'b0;
    $display("test_nyquist done");
  endtask
  // Disabled clock freezes the stream
  task automatic test_ce();
    logic [DDCND_OUT_W-1:0] heldI;
    int pulses;
    wait_outs(1);
    @(negedge clk);
    ce = 1'b0;
    heldI = outI;
    pulses = 0;
    repeat (40) begin
      @(negedge clk);
      if (outValid === 1'b1) pulses++;
    end
    ce = 1'b1;
    `CHECK_EQ("frozen outI", heldI, outI)
    `CHECK_EQ("pulses while off", 0, pulses)
    $display("test_ce done");
  endtask
  // Zero input at decimation 32 and the clamped maximum delay
  task automatic test_quiet();
    level = 12'h000;
    decimationSetting = 3'h5;
    downconv_sample_delay = 6'h3F;
    wait_outs(70);
    `CHECK_EQ("quiet outI", 15'h0000, outI)
    `CHECK_EQ("quiet outQ", 15'h0000, outQ)
    $display("test_quiet done");
  endtask
  task automatic complete_run();
    $display("Compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    level = 12'h3E8;
    osc_frequency_word = '0;
    for (int p = 0; p < DDCND_PRESETS; p++) begin
      osc_phase_offset_word[p*16 +: 16] = 16'(p) * 16'h2000; // Eighth turn, before any link
    end
    rational_step_divider = '0;
    rationalMode = 1'b0;
    preset_select_pins = 3'h0;
    preset_select_field = 3'h0;
    selectFromField = 1'b0;
    decimationSetting = 3'h0;
    downconv_sample_delay = 6'h00;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    test_rate();
    test_phase();
    test_nyquist();
    test_ce();
    test_quiet();
    complete_run();
  end
endmodule
`default_nettype wire
